//--- passive_cable_vdo_builder_tb_top.sv
// self-checking bench for the passive cable object builder
`timescale 1ns/1ns
`default_nettype none
`include "pcv_map.svh"
module passive_cable_vdo_builder_tb_top;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  awaddr = 4'h0;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [3:0]  araddr = 4'h0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        nv_load = 1'b0;
    logic [31:0] nv_cfg = 32'h0;
    logic [7:0]  nv_ctrl = 8'h0;
    logic        disc_req = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, send_en, err, resp_valid;
    logic [1:0]  bresp, rresp, rsp;
    logic [31:0] rdata, vdo, resp_word, rd, cfg;
    logic [7:0]  ctl;
    logic [3:0]  j;
    int          bad_count = 0;
    int          cmp_count = 0;

    always #10 aclk = ~aclk;

    pcv_builder uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .nv_load(nv_load), .nv_cfg(nv_cfg), .nv_ctrl(nv_ctrl),
        .vdo_word(vdo), .vdo_send_en(send_en), .cfg_error(err));

    pcv_port_model partner (.aclk(aclk), .aresetn(aresetn), .disc_req(disc_req),
        .vdo_word(vdo), .vdo_send_en(send_en), .resp_valid(resp_valid),
        .resp_word(resp_word));

    // =========================================
    // expected object, error flag and send enable
    function automatic logic [31:0] ev(input logic [31:0] c, input logic [7:0] k);
        logic [1:0] pl, te, cu;
        logic [3:0] la;
        logic [2:0] ss;
        pl = (c[19:18] < 2'h2) ? 2'h2 : c[19:18];
        la = (c[16:13] == 4'h0 || c[16:13] > 4'h8) ? 4'h8 : c[16:13];
        te = k[3] ? 2'h0 : ((c[12:11] > 2'h1) ? 2'h1 : c[12:11]);
        cu = (c[6:5] == 2'h1 || c[6:5] == 2'h2) ? c[6:5] : 2'h1;
        ss = (c[2:0] > 3'h2) ? 3'h0 : c[2:0];
        return {c[31:24], 3'h0, 1'b0, pl, 1'b0, la, te, c[10:9], 2'h0, cu, 2'h0, ss};
    endfunction

    function automatic logic er(input logic [31:0] c);
        return (c[19:18] < 2'h2) || (c[16:13] == 4'h0) || (c[16:13] > 4'h8)
            || (c[12:11] > 2'h1) || (c[6:5] == 2'h0) || (c[6:5] == 2'h3) || (c[2:0] > 3'h2);
    endfunction

    function automatic logic se(input logic [7:0] k);
        return (k[2:0] == 3'h3) || (k[2:0] == 3'h4);
    endfunction

    function automatic logic [4:0] fe(input logic [31:0] c);
        return {c[2:0] > 3'h2, (c[6:5] == 2'h0) || (c[6:5] == 2'h3), c[12:11] > 2'h1,
                (c[16:13] == 4'h0) || (c[16:13] > 4'h8), c[19:18] < 2'h2};
    endfunction

    // =========================================
    // compare, verdict and bus tasks
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic test_done;
        if (bad_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        logic a_ok, w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            a_ok |= (awready === 1'b1);
            w_ok |= (wready === 1'b1);
            if (a_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end while (!(a_ok && w_ok));
        do @(posedge aclk); while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    task automatic settle_chk(input logic [31:0] c, input logic [7:0] k);
        @(posedge aclk);
        #1;
        chk("vdo_word", vdo, ev(c, k));
        chk("cfg_error", 32'(err), 32'(er(c)));
        chk("send_en", 32'(send_en), 32'(se(k)));
    endtask

    // =========================================
    // test sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        settle_chk(`PCV_CFG_RST, 8'h0);
        rdr(`PCV_OFF_CFG); chk("cfg_reset", rd, `PCV_CFG_RST);
        for (int i = 0; i < 16; i++) begin
            j = i[3:0];
            ctl = {4'h0, j[3], j[2:0]};
            cfg = {j, ~j, j[2:0], j[0], j[1:0], j[1], j, j[2:1], j[1:0], j[3:2], j[1:0],
                   j[1:0], j[2:0]};
            wr(`PCV_OFF_CTRL, {24'hffffff, ctl}, 4'hf);
            wr(`PCV_OFF_CFG, cfg, 4'hf); chk("bresp", 32'(rsp), 32'(`PCV_RESP_OKAY));
            settle_chk(cfg, ctl);
            rdr(`PCV_OFF_VDO); chk("vdo_read", rd, ev(cfg, ctl));
            rdr(`PCV_OFF_STAT); chk("status", rd, {25'h0, fe(cfg), er(cfg), se(ctl)});
            rdr(`PCV_OFF_CTRL); chk("ctrl_read", rd, {24'h0, ctl});
            rdr(`PCV_OFF_CFG); chk("cfg_read", rd, cfg);
            @(posedge aclk); disc_req <= 1'b1;
            @(posedge aclk); disc_req <= 1'b0;
            #1;
            chk("resp_valid", 32'(resp_valid), 32'(se(ctl)));
            if (se(ctl)) chk("resp_word", resp_word, ev(cfg, ctl));
        end
        wr(`PCV_OFF_VDO, 32'h0, 4'hf); chk("ro_resp", 32'(rsp), 32'(`PCV_RESP_OKAY));
        wr(4'h1, 32'h0, 4'hf); chk("bad_wr", 32'(rsp), 32'(`PCV_RESP_SLVERR));
        rdr(4'h6); chk("bad_rd", 32'(rsp), 32'(`PCV_RESP_SLVERR));
        chk("bad_rdata", rd, 32'h0);
        settle_chk(cfg, ctl);
        wr(`PCV_OFF_CFG, `PCV_CFG_RST, 4'hf);
        wr(`PCV_OFF_CFG, 32'hffff_ff22, 4'h1);
        rdr(`PCV_OFF_CFG); chk("strobe", rd, 32'h0008_2022);
        settle_chk(32'h0008_2022, ctl);
        @(posedge aclk);
        nv_cfg <= 32'h7316_6c41; nv_ctrl <= 8'h0c; nv_load <= 1'b1;
        @(posedge aclk); nv_load <= 1'b0;
        settle_chk(32'h7316_6c41, 8'h0c);
        @(posedge aclk); aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        settle_chk(`PCV_CFG_RST, 8'h0);
        test_done();
    end

    initial begin
        repeat (5000) @(posedge aclk);
        bad_count++;
        test_done();
    end
endmodule
`default_nettype wire

//--- pcv_builder.sv
// passive cable object builder with axi4-lite register slave
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "pcv_map.svh"

// Functional notes
// - object offered whenever product type is passive cable or active cable
// - hardware version in bits 31:28, firmware version in bits 27:24
// - version field bits 23:21 always 000b, never reserved codes
// - single reserved bits 20 and 17 always zero
// - plug kind bits 19:18 only 10b or 11b
// - latency bits 16:13 only 0001b to 1000b
// - termination bits 12:11 only 00b or 01b
// - discover identity only plug sends termination 00b
// - maximum vbus voltage coded in bits 10:9, all four codes valid
// - reserved pairs 8:7 and 4:3 always zero
// - current capability bits 6:5 only 01b or 10b
// - superspeed bits 2:0 only 000b to 010b
module pcv_builder (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        nv_load,
    input  wire logic [31:0] nv_cfg,
    input  wire logic [7:0]  nv_ctrl,
    output logic [31:0]      vdo_word,
    output logic             vdo_send_en,
    output logic             cfg_error
);
    // =========================================================
    // state
    logic [31:0] cfg_r,      cfg_nxt;
    logic [7:0]  ctrl_r,     ctrl_nxt;
    logic [31:0] vdo_r,      vdo_nxt;
    logic        send_r,     send_nxt;
    logic        err_r,      err_nxt;
    logic [4:0]  ferr_r,     ferr_nxt;
    logic        aw_got_r,   aw_got_nxt;
    logic [3:0]  awaddr_r,   awaddr_nxt;
    logic        w_got_r,    w_got_nxt;
    logic [31:0] wdata_r,    wdata_nxt;
    logic [3:0]  wstrb_r,    wstrb_nxt;
    logic        bvalid_r,   bvalid_nxt;
    logic [1:0]  bresp_r,    bresp_nxt;
    logic        rvalid_r,   rvalid_nxt;
    logic [31:0] rdata_r,    rdata_nxt;
    logic [1:0]  rresp_r,    rresp_nxt;

    logic [1:0]  plug_f;
    logic [3:0]  lat_f;
    logic [1:0]  term_f;
    logic [1:0]  cur_f;
    logic [2:0]  ss_f;
    logic [4:0]  bad;
    logic        disc_only;
    logic        do_write;
    logic [31:0] wmerge;
    logic [31:0] ctrl_word;

    // =========================================================
    // field checks
    pcv_field_fix #(.W(2), .LO(`PCV_PLUG_TYPEC), .HI(`PCV_PLUG_CAPT),
                    .DEF(`PCV_PLUG_TYPEC)) u_plug (
        .field_in  (cfg_r[`PCV_F_PLUG]),
        .field_out (plug_f),
        .bad       (bad[0])
    );
    pcv_field_fix #(.W(4), .LO(`PCV_LAT_MIN), .HI(`PCV_LAT_MAX),
                    .DEF(`PCV_LAT_MAX)) u_lat (
        .field_in  (cfg_r[`PCV_F_LAT]),
        .field_out (lat_f),
        .bad       (bad[1])
    );
    pcv_field_fix #(.W(2), .LO(`PCV_TERM_NOVC), .HI(`PCV_TERM_VC),
                    .DEF(`PCV_TERM_VC)) u_term (
        .field_in  (cfg_r[`PCV_F_TERM]),
        .field_out (term_f),
        .bad       (bad[2])
    );
    pcv_field_fix #(.W(2), .LO(`PCV_CUR_3A), .HI(`PCV_CUR_5A),
                    .DEF(`PCV_CUR_3A)) u_cur (
        .field_in  (cfg_r[`PCV_F_CUR]),
        .field_out (cur_f),
        .bad       (bad[3])
    );
    pcv_field_fix #(.W(3), .LO(`PCV_SS_USB2), .HI(`PCV_SS_GEN2),
                    .DEF(`PCV_SS_USB2)) u_ss (
        .field_in  (cfg_r[`PCV_F_SS]),
        .field_out (ss_f),
        .bad       (bad[4])
    );

    // =========================================================
    // object assembly
    always_comb begin
        disc_only = ctrl_r[`PCV_C_DISC];
        vdo_nxt = '0;
        vdo_nxt[`PCV_F_HW]   = cfg_r[`PCV_F_HW];
        vdo_nxt[`PCV_F_FW]   = cfg_r[`PCV_F_FW];
        vdo_nxt[`PCV_F_VER]  = `PCV_VER_1P0;
        vdo_nxt[`PCV_F_PLUG] = plug_f;
        vdo_nxt[`PCV_F_LAT]  = lat_f;
        vdo_nxt[`PCV_F_TERM] = disc_only ? `PCV_TERM_NOVC : term_f;
        vdo_nxt[`PCV_F_VMAX] = cfg_r[`PCV_F_VMAX];
        vdo_nxt[`PCV_F_CUR]  = cur_f;
        vdo_nxt[`PCV_F_SS]   = ss_f;
        send_nxt = (ctrl_r[`PCV_C_PTYPE] == pcv_pkg::PCV_PT_PASSIVE) ||
                   (ctrl_r[`PCV_C_PTYPE] == pcv_pkg::PCV_PT_ACTIVE);
        ferr_nxt = bad;
        err_nxt  = |bad;
    end

    // =========================================================
    // axi4-lite write side
    always_comb begin
        aw_got_nxt = aw_got_r;
        awaddr_nxt = awaddr_r;
        w_got_nxt  = w_got_r;
        wdata_nxt  = wdata_r;
        wstrb_nxt  = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt  = bresp_r;
        cfg_nxt    = cfg_r;
        ctrl_nxt   = ctrl_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        do_write = aw_got_r && w_got_r && !bvalid_r;
        wmerge = (awaddr_r == `PCV_OFF_CFG) ? cfg_r : {24'h00_0000, ctrl_r};
        for (int i = 0; i < 4; i++) begin
            if (wstrb_r[i]) begin
                wmerge[i*8 +: 8] = wdata_r[i*8 +: 8];
            end
        end
        if (do_write) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = `PCV_RESP_OKAY;
            unique case (awaddr_r)
                `PCV_OFF_CFG:  cfg_nxt  = wmerge;
                `PCV_OFF_CTRL: ctrl_nxt = wmerge[7:0];
                `PCV_OFF_VDO,
                `PCV_OFF_STAT: bresp_nxt = `PCV_RESP_OKAY;
                default:       bresp_nxt = `PCV_RESP_SLVERR;
            endcase
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (nv_load) begin
            cfg_nxt  = nv_cfg;
            ctrl_nxt = nv_ctrl;
        end
    end

    // =========================================================
    // axi4-lite read side
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        ctrl_word  = {24'h00_0000, ctrl_r};
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `PCV_RESP_OKAY;
            unique case (s_axi_araddr)
                `PCV_OFF_CFG:  rdata_nxt = cfg_r;
                `PCV_OFF_CTRL: rdata_nxt = ctrl_word;
                `PCV_OFF_VDO:  rdata_nxt = vdo_r;
                `PCV_OFF_STAT: rdata_nxt = {25'h000_0000, ferr_r, err_r, send_r};
                default: begin
                    rdata_nxt = '0;
                    rresp_nxt = `PCV_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_comb begin
        s_axi_awready = !aw_got_r && !bvalid_r;
        s_axi_wready  = !w_got_r && !bvalid_r;
        s_axi_arready = !rvalid_r;
        s_axi_bvalid  = bvalid_r;
        s_axi_bresp   = bresp_r;
        s_axi_rvalid  = rvalid_r;
        s_axi_rdata   = rdata_r;
        s_axi_rresp   = rresp_r;
        vdo_word      = vdo_r;
        vdo_send_en   = send_r;
        cfg_error     = err_r;
    end

    // =========================================================
    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r    <= `PCV_CFG_RST;
            ctrl_r   <= `PCV_CTRL_RST;
            vdo_r    <= '0;
            send_r   <= 1'b0;
            err_r    <= 1'b0;
            ferr_r   <= '0;
            aw_got_r <= 1'b0;
            awaddr_r <= '0;
            w_got_r  <= 1'b0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
            bvalid_r <= 1'b0;
            bresp_r  <= `PCV_RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= `PCV_RESP_OKAY;
        end else begin
            cfg_r    <= cfg_nxt;
            ctrl_r   <= ctrl_nxt;
            vdo_r    <= vdo_nxt;
            send_r   <= send_nxt;
            err_r    <= err_nxt;
            ferr_r   <= ferr_nxt;
            aw_got_r <= aw_got_nxt;
            awaddr_r <= awaddr_nxt;
            w_got_r  <= w_got_nxt;
            wdata_r  <= wdata_nxt;
            wstrb_r  <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r  <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r  <= rdata_nxt;
            rresp_r  <= rresp_nxt;
        end
    end

    // =========================================================
    // checks
    send_when_a: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn |=> (send_r == (($past(ctrl_r[`PCV_C_PTYPE]) == pcv_pkg::PCV_PT_PASSIVE) ||
                        ($past(ctrl_r[`PCV_C_PTYPE]) == pcv_pkg::PCV_PT_ACTIVE))))
        else $error("send enable does not follow product type");
    hw_fw_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn |=> (vdo_r[`PCV_F_HW] == $past(cfg_r[`PCV_F_HW]) &&
                     vdo_r[`PCV_F_FW] == $past(cfg_r[`PCV_F_FW])))
        else $error("version nibbles not copied");
    ver_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        vdo_r[`PCV_F_VER] == `PCV_VER_1P0)
        else $error("object version not 000b");
    rsv_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !vdo_r[`PCV_F_RSV20] && !vdo_r[`PCV_F_RSV17])
        else $error("reserved single bit set");
    plug_legal_a: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn |=> (vdo_r[`PCV_F_PLUG] == (($past(cfg_r[`PCV_F_PLUG]) < `PCV_PLUG_TYPEC) ?
                     `PCV_PLUG_TYPEC : $past(cfg_r[`PCV_F_PLUG]))))
        else $error("plug code illegal");
    lat_legal_a: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn |=> (vdo_r[`PCV_F_LAT] >= `PCV_LAT_MIN && vdo_r[`PCV_F_LAT] <= `PCV_LAT_MAX))
        else $error("latency code illegal");
    term_legal_a: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn |=> (vdo_r[`PCV_F_TERM] <= `PCV_TERM_VC))
        else $error("termination code illegal");
    term_disc_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_r[`PCV_C_DISC] |=> (vdo_r[`PCV_F_TERM] == `PCV_TERM_NOVC))
        else $error("discover only plug not 00b");
    vmax_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn |=> (vdo_r[`PCV_F_VMAX] == $past(cfg_r[`PCV_F_VMAX])))
        else $error("voltage code not copied");
    rsv_pairs_a: assert property (@(posedge aclk) disable iff (!aresetn)
        vdo_r[`PCV_F_RSV8] == 2'h0 && vdo_r[`PCV_F_RSV4] == 2'h0)
        else $error("reserved pair set");
    cur_legal_a: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn |=> (vdo_r[`PCV_F_CUR] == `PCV_CUR_3A || vdo_r[`PCV_F_CUR] == `PCV_CUR_5A))
        else $error("current code illegal");
    ss_legal_a: assert property (@(posedge aclk) disable iff (!aresetn)
        vdo_r[`PCV_F_SS] <= `PCV_SS_GEN2)
        else $error("superspeed code illegal");
    word_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (aresetn && $past(aresetn) && $stable(cfg_r) && $stable(ctrl_r)) ##1
        ($stable(cfg_r) && $stable(ctrl_r)) |-> $stable(vdo_r))
        else $error("object changed without new settings");
    err_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn |=> (err_r == ($past(cfg_r[`PCV_F_PLUG]) < `PCV_PLUG_TYPEC ||
                       $past(cfg_r[`PCV_F_TERM]) > `PCV_TERM_VC ||
                       $past(cfg_r[`PCV_F_LAT]) == 4'h0 ||
                       $past(cfg_r[`PCV_F_LAT]) > `PCV_LAT_MAX ||
                       $past(cfg_r[`PCV_F_CUR]) == 2'h0 ||
                       $past(cfg_r[`PCV_F_CUR]) == 2'h3 ||
                       $past(cfg_r[`PCV_F_SS]) > `PCV_SS_GEN2)))
        else $error("error flag wrong");
endmodule
`default_nettype wire

//--- pcv_field_fix.sv
// range check and substitution for one coded field
`timescale 1ns/1ns
`default_nettype none
module pcv_field_fix #(
    parameter int           W   = 2,
    parameter logic [W-1:0] LO  = '0,
    parameter logic [W-1:0] HI  = '1,
    parameter logic [W-1:0] DEF = '0
) (
    input  wire logic [W-1:0] field_in,
    output logic      [W-1:0] field_out,
    output logic              bad
);
    // out of range codes are replaced so they never leave the block
    always_comb begin
        bad       = (field_in < LO) || (field_in > HI);
        field_out = bad ? DEF : field_in;
    end
endmodule
`default_nettype wire

//--- pcv_map.svh
// register offsets, field ranges and reset values of the cable object builder
`ifndef PCV_MAP_SVH
`define PCV_MAP_SVH

`define PCV_OFF_CFG      4'h0
`define PCV_OFF_CTRL     4'h4
`define PCV_OFF_VDO      4'h8
`define PCV_OFF_STAT     4'hc

`define PCV_CFG_RST      32'h0008_2020
`define PCV_CTRL_RST     8'h00

`define PCV_F_HW         31:28
`define PCV_F_FW         27:24
`define PCV_F_VER        23:21
`define PCV_F_RSV20      20
`define PCV_F_PLUG       19:18
`define PCV_F_RSV17      17
`define PCV_F_LAT        16:13
`define PCV_F_TERM       12:11
`define PCV_F_VMAX       10:9
`define PCV_F_RSV8       8:7
`define PCV_F_CUR        6:5
`define PCV_F_RSV4       4:3
`define PCV_F_SS         2:0

`define PCV_C_PTYPE      2:0
`define PCV_C_DISC       3

`define PCV_VER_1P0      3'h0
`define PCV_PLUG_TYPEC   2'h2
`define PCV_PLUG_CAPT    2'h3
`define PCV_LAT_MIN      4'h1
`define PCV_LAT_MAX      4'h8
`define PCV_TERM_NOVC    2'h0
`define PCV_TERM_VC      2'h1
`define PCV_CUR_3A       2'h1
`define PCV_CUR_5A       2'h2
`define PCV_SS_USB2      3'h0
`define PCV_SS_GEN2      3'h2

`define PCV_RESP_OKAY    2'h0
`define PCV_RESP_SLVERR  2'h2

`endif

//--- pcv_pkg.sv
// types shared by the cable object builder
package pcv_pkg;
    typedef enum logic [2:0] {
        PCV_PT_NONE    = 3'h0,
        PCV_PT_PASSIVE = 3'h3,
        PCV_PT_ACTIVE  = 3'h4
    } pcv_ptype_e;
endpackage

//--- pcv_port_model.sv
// port controller model answering identity discovery from the cable object
`timescale 1ns/1ns
`default_nettype none
module pcv_port_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        disc_req,
    input  wire logic [31:0] vdo_word,
    input  wire logic        vdo_send_en,
    output logic             resp_valid,
    output logic [31:0]      resp_word
);
    // =========================================
    // answer capture, stale word inverted each cycle without an answered request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            resp_valid <= 1'b0;
            resp_word  <= 32'h0;
        end else begin
            resp_valid <= disc_req && vdo_send_en;
            resp_word  <= (disc_req && vdo_send_en) ? vdo_word : ~resp_word;
        end
    end
endmodule
`default_nettype wire
